// file: design/dspr_top.sv
// power enable combining, per section reset release and clock buffer gating
// Behaviour
// - regulators enabled whenever either power enable input is high.
// - wlan enable high keeps regulators on and releases wlan section reset.
// - wlan enable low holds wlan section in reset, whatever the other input.
// - regulators disabled only when both power enable inputs are low.
// - both pull-downs on after power-up; software may disable each one.
// - reference clock input buffer off in sleep, on when sleep ends while either power enable input is high.
// - second radio enable holds its section in reset while low.
// - after full regulator shutdown the block restarts as from power-up.
module dspr_top
    import dspr_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic wlan_power_enable_in,
    input  wire logic second_radio_power_enable_in,
    input  wire logic sleep_req,
    input  wire logic pulldown_wlan_disable,
    input  wire logic pulldown_radio2_disable,
    output logic      regulator_enable,
    output logic      wlan_reset_n,
    output logic      radio2_reset_n,
    output logic      wlan_pulldown_enable,
    output logic      radio2_pulldown_enable,
    output logic      ref_clk_buffer_enable
);
    dspr_pair_t en_sync;
    dspr_pair_t en_prev_r;
    logic [3:0] wlan_cnt_r;
    logic [3:0] radio2_cnt_r;
    logic       any_en;
    logic       wlan_sync;
    logic       radio2_sync;
    logic       sleep_sync;

    dspr_sync u_sync_wlan (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (wlan_power_enable_in),
        .dout    (wlan_sync)
    );
    dspr_sync u_sync_radio2 (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (second_radio_power_enable_in),
        .dout    (radio2_sync)
    );

    // sleep request comes from the power_sequencer on its own clock
    dspr_sync u_sync_sleep (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (sleep_req),
        .dout    (sleep_sync)
    );

    // one carrier so both sections are judged on the same edge
    assign en_sync = '{wlan: wlan_sync, radio2: radio2_sync};

    assign any_en = en_sync.wlan | en_sync.radio2;

    // regulators off only with both low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regulator_enable <= REG_EN_RESET_VAL;
        end else begin
            regulator_enable <= any_en;
        end
    end

    reg_follows_or_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        any_en |=> regulator_enable)
        else $error("regulators not enabled with an enable high");

    reg_off_both_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!en_sync.wlan && !en_sync.radio2) |=> !regulator_enable)
        else $error("regulators on with both enables low");

    reg_on_wlan_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        en_sync.wlan |=> regulator_enable)
        else $error("regulators off while wlan enable high");

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            en_prev_r <= '0;
        end else begin
            en_prev_r <= en_sync;
        end
    end

    // a change seen inside must match the pin two edges back
    sync_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        en_sync.wlan != en_prev_r.wlan |-> $past(wlan_power_enable_in, 2) == en_sync.wlan)
        else $error("wlan enable not two-flop synchronised");

    radio2_sync_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        en_sync.radio2 != en_prev_r.radio2
        |-> $past(second_radio_power_enable_in, 2) == en_sync.radio2)
        else $error("second radio enable not two-flop synchronised");

    // wlan reset held while enable low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wlan_cnt_r   <= '0;
            wlan_reset_n <= SECTION_RESET_VAL;
        end else if (!en_sync.wlan) begin
            wlan_cnt_r   <= '0;
            wlan_reset_n <= 1'b0;
        end else if (wlan_cnt_r < RELEASE_CYCLES) begin
            wlan_cnt_r   <= wlan_cnt_r + 4'h1;
        end else begin
            wlan_reset_n <= 1'b1;
        end
    end

    wlan_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !en_sync.wlan |=> !wlan_reset_n)
        else $error("wlan section out of reset while enable low");

    wlan_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(en_sync.wlan) ##1 en_sync.wlan [*4] |=> wlan_reset_n)
        else $error("wlan reset not released");

    // settle window assumes the default release count of two
    wlan_settle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(en_sync.wlan) |=> (!wlan_reset_n) [*2])
        else $error("wlan reset released before settle time");

    wlan_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (en_sync.wlan && wlan_reset_n) |=> wlan_reset_n)
        else $error("wlan section fell back into reset while enabled");

    // second radio reset mirrors the wlan path
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            radio2_cnt_r   <= '0;
            radio2_reset_n <= SECTION_RESET_VAL;
        end else if (!en_sync.radio2) begin
            radio2_cnt_r   <= '0;
            radio2_reset_n <= 1'b0;
        end else if (radio2_cnt_r < RELEASE_CYCLES) begin
            radio2_cnt_r   <= radio2_cnt_r + 4'h1;
        end else begin
            radio2_reset_n <= 1'b1;
        end
    end

    radio2_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !en_sync.radio2 |=> !radio2_reset_n)
        else $error("second radio out of reset while enable low");

    radio2_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(en_sync.radio2) ##1 en_sync.radio2 [*4] |=> radio2_reset_n)
        else $error("second radio reset not released");

    radio2_settle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(en_sync.radio2) |=> (!radio2_reset_n) [*2])
        else $error("second radio reset released before settle time");

    radio2_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (en_sync.radio2 && radio2_reset_n) |=> radio2_reset_n)
        else $error("second radio fell back into reset while enabled");

    // pull-downs default on, software may turn off
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wlan_pulldown_enable   <= PULLDOWN_RESET_VAL;
            radio2_pulldown_enable <= PULLDOWN_RESET_VAL;
        end else if (!any_en) begin
            wlan_pulldown_enable   <= PULLDOWN_RESET_VAL;
            radio2_pulldown_enable <= PULLDOWN_RESET_VAL;
        end else begin
            wlan_pulldown_enable   <= !pulldown_wlan_disable;
            radio2_pulldown_enable <= !pulldown_radio2_disable;
        end
    end

    pulldown_ctl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (any_en && pulldown_wlan_disable) |=> !wlan_pulldown_enable)
        else $error("wlan pull-down not disabled by control");

    radio2_pd_ctl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (any_en && pulldown_radio2_disable) |=> !radio2_pulldown_enable)
        else $error("second radio pull-down not disabled by control");

    pulldown_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (any_en && !pulldown_wlan_disable && !pulldown_radio2_disable)
        |=> (wlan_pulldown_enable && radio2_pulldown_enable))
        else $error("pull-down off without a disable request");

    // both enables low stands for a full power cycle
    shutdown_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !any_en |=> (wlan_pulldown_enable && radio2_pulldown_enable && !wlan_reset_n))
        else $error("state retained through shutdown");

    // clock buffer follows sleep and power
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_clk_buffer_enable <= CLKBUF_RESET_VAL;
        end else begin
            ref_clk_buffer_enable <= any_en & !sleep_sync;
        end
    end

    clkbuf_sleep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sleep_sync |=> !ref_clk_buffer_enable)
        else $error("clock buffer on during sleep");

    clkbuf_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (any_en && !sleep_sync) |=> ref_clk_buffer_enable)
        else $error("clock buffer off after leaving sleep");

    // buffer has no supply once the regulators are down
    clkbuf_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !any_en |=> !ref_clk_buffer_enable)
        else $error("clock buffer on with regulators off");
endmodule

// file: design/dspr_pkg.sv
// shared constants and carrier types for the dual section power and reset control
package dspr_pkg;
    localparam int        SYNC_STAGES        = 2;
    localparam logic      PULLDOWN_RESET_VAL = 1'b1;
    localparam logic      SECTION_RESET_VAL  = 1'b0;
    localparam logic      REG_EN_RESET_VAL   = 1'b0;
    localparam logic      CLKBUF_RESET_VAL   = 1'b0;
    localparam int        RELEASE_DELAY_NS   = 20;
    localparam int        CLK_PERIOD_NS      = 10;
    localparam logic [3:0] RELEASE_CYCLES    =
        4'((RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef struct packed {
        logic wlan;
        logic radio2;
    } dspr_pair_t;
endpackage

// file: design/dspr_sync.sv
// two flop level synchroniser with constant reset value
module dspr_sync (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule

// file: tb/dspr_host.sv
// host logic model driving both power enable pins
module dspr_host
    import dspr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire dspr_pair_t req,
    output dspr_pair_t      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = '0;
    // host logic changes its pins only just after a falling edge
    always @(negedge clk_sys) begin
        pin <= req;
    end
endmodule

// file: tb/dspr_top_tb_top.sv
// self checking bench for power enable combining and section resets
module dspr_top_tb_top
    import dspr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       sleep_req = 1'b0;
    dspr_pair_t req = '0;
    dspr_pair_t pd_dis = '0;
    dspr_pair_t pin;
    logic       reg_en, wl_rn, r2_rn, wl_pd, r2_pd, buf_en;
    int         failures = 0;
    int         n_compared = 0;
    int         cycles = 0;
    always #5 clk_sys = ~clk_sys;
    dspr_host u_host (.clk_sys(clk_sys), .req(req), .pin(pin));
    dspr_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wlan_power_enable_in(pin.wlan),
        .second_radio_power_enable_in(pin.radio2), .sleep_req(sleep_req),
        .pulldown_wlan_disable(pd_dis.wlan), .pulldown_radio2_disable(pd_dis.radio2),
        .regulator_enable(reg_en), .wlan_reset_n(wl_rn), .radio2_reset_n(r2_rn),
        .wlan_pulldown_enable(wl_pd), .radio2_pulldown_enable(r2_pd),
        .ref_clk_buffer_enable(buf_en));
    task automatic check(input string what, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // pins follow one falling edge after the request
    task automatic put(input logic w, input logic r);
        req <= '{wlan: w, radio2: r};
        step(1);
    endtask
    task automatic t_reset_vals;
        check("reg_en", reg_en, 1'b0);
        check("wl_rn", wl_rn, 1'b0);
        check("r2_rn", r2_rn, 1'b0);
        check("wl_pd", wl_pd, 1'b1);
        check("r2_pd", r2_pd, 1'b1);
        check("buf_en", buf_en, 1'b0);
    endtask
    task automatic t_wlan_up;
        put(1'b1, 1'b0);
        step(2);
        check("reg_en early", reg_en, 1'b0);
        step(1);
        check("reg_en", reg_en, 1'b1);
        check("buf_en", buf_en, 1'b1);
        step(1);
        check("wl_rn early", wl_rn, 1'b0);
        step(1);
        check("wl_rn", wl_rn, 1'b1);
        check("r2_rn", r2_rn, 1'b0);
    endtask
    task automatic t_sleep;
        sleep_req <= 1'b1;
        step(2);
        check("buf_en early", buf_en, 1'b1);
        step(1);
        check("buf_en sleep", buf_en, 1'b0);
        sleep_req <= 1'b0;
        step(2);
        check("buf_en wake early", buf_en, 1'b0);
        step(1);
        check("buf_en wake", buf_en, 1'b1);
    endtask
    task automatic t_radio2_only;
        put(1'b0, 1'b1);
        step(3);
        check("wl_rn", wl_rn, 1'b0);
        check("reg_en", reg_en, 1'b1);
        step(3);
        check("r2_rn", r2_rn, 1'b1);
    endtask
    task automatic t_pulldown;
        pd_dis <= '{wlan: 1'b1, radio2: 1'b0};
        step(1);
        check("wl_pd alone", wl_pd, 1'b0);
        check("r2_pd kept", r2_pd, 1'b1);
        pd_dis <= '1;
        step(1);
        check("wl_pd off", wl_pd, 1'b0);
        check("r2_pd off", r2_pd, 1'b0);
        put(1'b0, 1'b0);
        step(3);
        check("reg_en off", reg_en, 1'b0);
        check("r2_rn", r2_rn, 1'b0);
        check("wl_pd forced", wl_pd, 1'b1);
        check("r2_pd forced", r2_pd, 1'b1);
        pd_dis <= '0;
        put(1'b1, 1'b1);
        step(4);
        check("r2_rn fresh", r2_rn, 1'b0);
        step(1);
        check("r2_rn", r2_rn, 1'b1);
        check("wl_rn", wl_rn, 1'b1);
    endtask
    task automatic results;
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // whole sequence needs well under a hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            results();
        end
    end
    initial begin
        step(3);
        rst_n <= 1'b1;
        step(1);
        t_reset_vals();
        t_wlan_up();
        t_sleep();
        t_radio2_only();
        t_pulldown();
        results();
    end
endmodule
